// ==== design/dzr_regs.vh ====
`ifndef DZR_REGS_VH
`define DZR_REGS_VH
// program word layout
`define DZR_WORD_W 16
`define DZR_ADDR_HI 10
`define DZR_ADDR_LO 9
`define DZR_ZD_BIT 8
`define DZR_SF_HI 7
`define DZR_SF_LO 6
`define DZR_OPE_BIT 2
`define DZR_REG_FMT 2'h3
`define DZR_REG_OPR 2'h2
// rate group codes
`define DZR_SF_44K 2'h0
`define DZR_SF_48K 2'h1
// reset values
`define DZR_SF_RST 2'h0
`define DZR_ZD_RST 1'h0
`define DZR_OPE_RST 1'h0
// timing counts
`define DZR_ZERO_RUN 65536
`define DZR_INIT_CLKS 1024
`define DZR_LAT_NUM 89
`define DZR_LAT_DEN 8
`define DZR_OSR 48
`define DZR_SYS_RATIO 384
`endif

// ==== design/dzr_modulator.v ====
`timescale 1ns/10ps
`include "dzr_regs.vh"
// third-order error-feedback modulator, five output levels
module dzr_modulator #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire step_i,
  input wire clear_i,
  input wire signed [W-1:0] sample_i,
  output reg [2:0] level_o
);
  localparam AW = W + 6;
  reg signed [AW-1:0] e1;
  reg signed [AW-1:0] e2;
  reg signed [AW-1:0] e3;
  reg signed [AW-1:0] v;
  reg signed [AW-1:0] q;
  reg signed [2:0] lv;
  // one quantiser level is a quarter of the input full scale
  localparam signed [AW-1:0] STEP = {{(AW-W+1){1'b0}}, 1'b1, {(W-2){1'b0}}};
  localparam signed [AW-1:0] HALF = {{(AW-W+2){1'b0}}, 1'b1, {(W-3){1'b0}}};
  localparam signed [AW-1:0] THR_HI = STEP + HALF;
  // noise shaping 1 + 3z^-1 - 3z^-2 + z^-3 on the quantiser error
  always @* begin
    v = $signed({{(AW-W){sample_i[W-1]}}, sample_i}) + (e1 <<< 1) + e1
      - (e2 <<< 1) - e2 + e3;
    if (v >= THR_HI) lv = 3'sd2;
    else if (v >= HALF) lv = 3'sd1;
    else if (v > -HALF) lv = 3'sd0;
    else if (v > -THR_HI) lv = -3'sd1;
    else lv = -3'sd2;
    q = lv * STEP;
  end
  // error history and level register, midscale code 2
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e1 <= {AW{1'b0}};
      e2 <= {AW{1'b0}};
      e3 <= {AW{1'b0}};
      level_o <= 3'h2;
    end else if (clear_i) begin
      e1 <= {AW{1'b0}};
      e2 <= {AW{1'b0}};
      e3 <= {AW{1'b0}};
      level_o <= 3'h2;
    end else if (step_i) begin
      e1 <= q - v;
      e2 <= e1;
      e3 <= e2;
      level_o <= lv + 3'sd2;
    end
  end
endmodule

// ==== design/dzr_top.v ====
`timescale 1ns/10ps
`include "dzr_regs.vh"
module dzr_top #(
  parameter W = 16,
  parameter ZERO_RUN = `DZR_ZERO_RUN,
  parameter INIT_CLKS = `DZR_INIT_CLKS
) (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire PROGRAM_LATCH_I,
  input wire PROGRAM_SHIFT_CLOCK_I,
  input wire PROGRAM_SERIAL_DATA_I,
  input wire AUDIO_BIT_CLOCK_I,
  input wire SAMPLE_VALID_I,
  input wire [W-1:0] SAMPLE_I,
  output reg [1:0] RATE_GROUP_O,
  output wire ZERO_RUN_DETECT_EN_O,
  output reg OUTPUT_MIDSCALE_O,
  output wire [2:0] LEVEL_O
);
  localparam ST_RESET = 3'h1;
  localparam ST_INIT = 3'h2;
  localparam ST_RUN = 3'h4;
  localparam LAT_STEPS = (`DZR_LAT_NUM * `DZR_OSR) / `DZR_LAT_DEN;
  localparam DIV = `DZR_SYS_RATIO / `DZR_OSR;
  // ************************************************************
  // decode helpers
  // ************************************************************
  // true when the address field of a program word names reg_code
  function addr_is;
    input [15:0] word;
    input [1:0] reg_code;
    begin
      addr_is = (word[`DZR_ADDR_HI:`DZR_ADDR_LO] == reg_code);
    end
  endfunction
  // rising edge between the last two stages of a synchroniser
  function rise_of;
    input [2:0] taps;
    begin
      rise_of = taps[1] & ~taps[2];
    end
  endfunction
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  reg [2:0] ml_s;
  reg [2:0] mc_s;
  reg [1:0] md_s;
  reg [2:0] bck_s;
  // two stages, third stage only for edge detection
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ml_s <= 3'h0;
      mc_s <= 3'h0;
      md_s <= 2'h0;
      bck_s <= 3'h0;
    end else begin
      ml_s <= {ml_s[1:0], PROGRAM_LATCH_I};
      mc_s <= {mc_s[1:0], PROGRAM_SHIFT_CLOCK_I};
      md_s <= {md_s[0], PROGRAM_SERIAL_DATA_I};
      bck_s <= {bck_s[1:0], AUDIO_BIT_CLOCK_I};
    end
  end
  // edges come from stages two and three, stage one is never read
  wire mc_rise = rise_of(mc_s);
  wire ml_rise = rise_of(ml_s);
  wire bck_rise = rise_of(bck_s);
  // ************************************************************
  // reset sequencing
  // ************************************************************
  reg [2:0] state;
  reg [10:0] init_cnt;
  wire running = (state == ST_RUN);
  // por and pin reset both enter ST_RESET via the async clear
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_RESET;
      init_cnt <= 11'h0;
    end else begin
      case (state)
        ST_RESET: begin
          state <= ST_INIT;
          init_cnt <= 11'h0;
        end
        ST_INIT: begin
          init_cnt <= init_cnt + 11'h1;
          if (init_cnt == INIT_CLKS - 2) state <= ST_RUN;
        end
        ST_RUN: state <= ST_RUN;
        default: state <= ST_RESET;
      endcase
    end
  end
  // ************************************************************
  // serial program port
  // ************************************************************
  reg [15:0] shreg;
  reg zd_en;
  reg output_force_midscale;
  // serial port is disabled while not running
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      shreg <= 16'h0;
      RATE_GROUP_O <= `DZR_SF_RST;
      zd_en <= `DZR_ZD_RST;
      output_force_midscale <= `DZR_OPE_RST;
    end else if (running) begin
      if (mc_rise) shreg <= {shreg[14:0], md_s[1]};
      if (ml_rise) begin
        if (addr_is(shreg, `DZR_REG_FMT)) begin
          zd_en <= shreg[`DZR_ZD_BIT];
          // reserved codes ignored
          if (!shreg[`DZR_SF_HI])
            RATE_GROUP_O <= shreg[`DZR_SF_HI:`DZR_SF_LO];
        end
        if (addr_is(shreg, `DZR_REG_OPR))
          output_force_midscale <= shreg[`DZR_OPE_BIT];
      end
    end
  end
  assign ZERO_RUN_DETECT_EN_O = zd_en;
  // ************************************************************
  // zero-run detector
  // ************************************************************
  reg [16:0] zrun;
  reg zforce;
  reg in_zero;
  // a nonzero sample has priority over the count, so a run that ends
  // on the very edge of the limit never forces midscale
  // counts bit-clock rises while the last sample was zero
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      zrun <= 17'h0;
      zforce <= 1'b0;
      in_zero <= 1'b0;
    end else if (!zd_en || !running) begin
      zrun <= 17'h0;
      zforce <= 1'b0;
      in_zero <= 1'b0;
    end else if (SAMPLE_VALID_I && SAMPLE_I != {W{1'b0}}) begin
      zrun <= 17'h0;
      zforce <= 1'b0;
      in_zero <= 1'b0;
    end else begin
      if (SAMPLE_VALID_I) in_zero <= 1'b1;
      if (in_zero && bck_rise && !zforce) begin
        zrun <= zrun + 17'h1;
        if (zrun == ZERO_RUN - 1) zforce <= 1'b1;
      end
    end
  end
  // ************************************************************
  // latency line and modulator pacing
  // ************************************************************
  reg [3:0] div_cnt;
  reg [W-1:0] hold;
  reg [W-1:0] dly [0:LAT_STEPS-1];
  wire step = running && (div_cnt == DIV - 1);
  integer i;
  // 48 modulator steps per sample at 384fs, delay of 534 steps
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_cnt <= 4'h0;
      hold <= {W{1'b0}};
    end else begin
      div_cnt <= (div_cnt == DIV - 1) ? 4'h0 : div_cnt + 4'h1;
      if (SAMPLE_VALID_I) hold <= SAMPLE_I;
    end
  end
  // shift line, no reset on storage
  always @(posedge MCLK_I) begin
    if (step) begin
      dly[0] <= hold;
      for (i = 1; i < LAT_STEPS; i = i + 1) dly[i] <= dly[i-1];
    end
  end
  // ************************************************************
  // latency line fill tracking
  // ************************************************************
  reg [9:0] fill;
  wire filled = (fill == LAT_STEPS);
  // modulator sees zero until the line holds written data only
  wire [W-1:0] line_out = filled ? dly[LAT_STEPS-1] : {W{1'b0}};
  // storage has no reset, so stale or unknown words must not reach
  // the shaper; ten bits cover a line of up to 1023 stages
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) fill <= 10'h0;
    else if (!running) fill <= 10'h0;
    else if (step && !filled) fill <= fill + 10'h1;
  end
  // midscale when not running, disabled or zero forced
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) OUTPUT_MIDSCALE_O <= 1'b1;
    else OUTPUT_MIDSCALE_O <= !running || output_force_midscale || zforce;
  end
  dzr_modulator #(.W(W)) u_mod (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .step_i(step),
    .clear_i(OUTPUT_MIDSCALE_O),
    .sample_i(line_out),
    .level_o(LEVEL_O)
  );
endmodule

// ==== testbench/dzr_monitor.sv ====
`timescale 1ns/10ps
// ***
// port checker
// ***
module dzr_monitor #(
  parameter W = 16
) (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire PROGRAM_LATCH_I,
  input wire SAMPLE_VALID_I,
  input wire [W-1:0] SAMPLE_I,
  input wire [1:0] RATE_GROUP_O,
  input wire ZERO_RUN_DETECT_EN_O,
  input wire OUTPUT_MIDSCALE_O,
  input wire [2:0] LEVEL_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // reset and init hold midscale
  rst_mid_a: assert property ($rose(RST_N_I) |->
    OUTPUT_MIDSCALE_O && LEVEL_O == 3'h2) else $error("reset level");
  init_hold_a: assert property ($rose(RST_N_I) |->
    OUTPUT_MIDSCALE_O [*8]) else $error("init too short");
  rate_legal_a: assert property (!RATE_GROUP_O[1])
    else $error("reserved rate");
  level_range_a: assert property (LEVEL_O <= 3'h4)
    else $error("level range");
  // fields move only after a latch
  rate_load_a: assert property ($changed(RATE_GROUP_O) |->
    $past(PROGRAM_LATCH_I, 3)) else $error("rate moved");
  zd_load_a: assert property ($changed(ZERO_RUN_DETECT_EN_O) |->
    $past(PROGRAM_LATCH_I, 3)) else $error("enable moved");
  mid_cause_a: assert property ($rose(OUTPUT_MIDSCALE_O) |->
    ZERO_RUN_DETECT_EN_O || $past(PROGRAM_LATCH_I, 3))
    else $error("midscale cause");
  mid_zero_a: assert property ($rose(OUTPUT_MIDSCALE_O) &&
    !$past(PROGRAM_LATCH_I, 3) |-> !($past(SAMPLE_VALID_I, 2) &&
    $past(SAMPLE_I, 2) != {W{1'b0}})) else $error("forced on data");
endmodule
bind dzr_top dzr_monitor #(.W(W)) i_mon (.MCLK_I(MCLK_I),
  .RST_N_I(RST_N_I), .PROGRAM_LATCH_I(PROGRAM_LATCH_I),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_I(SAMPLE_I),
  .RATE_GROUP_O(RATE_GROUP_O), .LEVEL_O(LEVEL_O),
  .ZERO_RUN_DETECT_EN_O(ZERO_RUN_DETECT_EN_O),
  .OUTPUT_MIDSCALE_O(OUTPUT_MIDSCALE_O));

// ==== testbench/dzr_host.sv ====
`timescale 1ns/10ps
// ***
// host port and bit clock
// ***
module dzr_host (
  input wire clk_i,
  output reg latch_o,
  output reg sclk_o,
  output reg sdat_o,
  output reg bck_o
);
  // pins idle low from the start
  initial begin
    latch_o = 1'b0;
    sclk_o = 1'b0;
    sdat_o = 1'b0;
    bck_o = 1'b0;
  end
  // bit clock runs free
  always #200 bck_o = ~bck_o;
  // one pin phase, four clocks
  task ph(input l, input c, input d);
    begin
      @(posedge clk_i);
      latch_o <= l;
      sclk_o <= c;
      sdat_o <= d;
      repeat (3) @(posedge clk_i);
    end
  endtask
  // word msb first, latch, spacing
  task send(input [15:0] w);
    integer i;
    begin
      for (i = 15; i >= 0; i = i - 1) begin
        ph(1'b0, 1'b0, w[i]);
        ph(1'b0, 1'b1, w[i]);
      end
      ph(1'b1, 1'b0, ~w[0]);
      ph(1'b0, 1'b0, ~w[0]);
      repeat (401) @(posedge clk_i);
    end
  endtask
endmodule

// ==== testbench/dzr_top_bench.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t mismatch", $time); end end
module dzr_top_bench;
  reg mclk = 1'b0;
  reg rst_n;
  reg vld;
  reg [15:0] smp;
  wire lat, sck, sd, bck, zd, mid;
  wire [1:0] rate;
  wire [2:0] lvl;
  integer fails = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer c;
  always #25 mclk = ~mclk;
  dzr_host i_host (.clk_i(mclk), .latch_o(lat), .sclk_o(sck),
    .sdat_o(sd), .bck_o(bck));
  dzr_top #(.ZERO_RUN(64), .INIT_CLKS(16)) i_dut (.MCLK_I(mclk),
    .RST_N_I(rst_n), .PROGRAM_LATCH_I(lat), .PROGRAM_SHIFT_CLOCK_I(sck),
    .PROGRAM_SERIAL_DATA_I(sd), .AUDIO_BIT_CLOCK_I(bck),
    .SAMPLE_VALID_I(vld), .SAMPLE_I(smp), .RATE_GROUP_O(rate),
    .ZERO_RUN_DETECT_EN_O(zd), .OUTPUT_MIDSCALE_O(mid), .LEVEL_O(lvl));
  task report_and_stop;
    begin
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // cycle ceiling
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  task clk_n(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task bits(input integer n);
    begin
      repeat (n) @(posedge bck);
      clk_n(4);
    end
  endtask
  task put(input [15:0] s);
    begin
      @(posedge mclk);
      smp <= s;
      vld <= 1'b1;
      @(posedge mclk);
      vld <= 1'b0;
    end
  endtask
  // reset, then init length
  task do_reset;
    begin
      @(posedge mclk);
      rst_n <= 1'b0;
      clk_n(2);
      `CHK({mid, lvl, rate, zd}, 7'h50)
      rst_n <= 1'b1;
      clk_n(13);
      `CHK(mid, 1'b1)
      clk_n(8);
      `CHK(mid, 1'b0)
    end
  endtask
  // all rate codes, wrong address
  task t_rate;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        i_host.send({7'h03, 1'b0, c[1:0], 6'h00});
        `CHK(rate, c > 1 ? 2'h1 : c[1:0])
      end
      i_host.send(16'h0200);
      `CHK(rate, 2'h1)
      i_host.send(16'h0700);
      `CHK({zd, rate}, 3'h4)
    end
  endtask
  // zero run forcing and restart
  task t_zero;
    begin
      put(16'h0000);
      bits(60);
      `CHK(mid, 1'b0)
      bits(6);
      `CHK(mid, 1'b1)
      put(16'h0123);
      clk_n(3);
      `CHK(mid, 1'b0)
      put(16'h0000);
      bits(32);
      put(16'hFFFF);
      put(16'h0000);
      bits(60);
      `CHK(mid, 1'b0)
    end
  endtask
  // detector off, disable bit, reset
  task t_misc;
    begin
      i_host.send(16'h0640);
      put(16'h0001);
      put(16'h0000);
      bits(72);
      `CHK(mid, 1'b0)
      i_host.send(16'h0404);
      put(16'h0100);
      `CHK(mid, 1'b1)
      i_host.send(16'h0400);
      put(16'h0100);
      clk_n(3);
      `CHK(mid, 1'b0)
      do_reset;
    end
  endtask
  // one sample through the line: 11.125 periods of 384 clocks
  task t_lat;
    integer n;
    begin
      put(16'h4000);
      n = 0;
      while (lvl === 3'h2 && n < 5000) begin
        clk_n(1);
        n = n + 1;
      end
      `CHK(n >= 4264 && n <= 4288, 1'b1)
      `CHK(lvl, 3'h3)
    end
  endtask
  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    smp = 16'h0000;
    do_reset;
    t_rate;
    t_zero;
    t_misc;
    t_lat;
    report_and_stop;
  end
endmodule
